// >>> core/lnmwrc_top.sv
// lnmwrc_top: mode sequencing, wake reporting and reset output of a lin node
// How it works
// R1 - after reset the mode is always stand-by, ignoring mode inputs
// R2 - normal mode with enable low and standby-select high goes to stand-by
// R3 - sleep leaves only to stand-by, only on local or remote wake
// R4 - stand-by: regulator and receiver on, transmitter off, termination off
// R5 - normal mode with enable and standby-select both low enters sleep
// R6 - sleep: termination disconnected and regulator switched off
// R7 - local wake only in sleep, on any edge of the wake input
// R8 - remote wake needs falling edge, long dominant, then rising edge
// R9 - remote wake seen in stand-by and sleep; sleep then goes stand-by
// R10 - stand-by receive output high, but low after remote wake until normal
// R11 - supply below threshold longer than filter time flags supply low
// R12 - supply low drives reset low and forces stand-by
// R13 - after recovery reset stays low about 6 ms more
// R14 - sleep drives reset low at once, whatever the supply
// R15 - while reset is low the mode inputs are ignored; the wake input still acts in sleep
// R16 - enable rising with transmit data high enters normal slope mode
// R17 - enable rising with transmit data low: low slope, transmitter waits
// R18 - entering normal from stand-by, inhibit high if standby-select high
// R19 - normal modes: receive output follows bus level
// R20 - other input combinations keep the mode; timing uses counters
`default_nettype none
module lnmwrc_top
    import lnmwrc_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_FILTER_CYC,
    parameter int FILTER_CYC = SUPPLY_LOW_FILTER_CYC,
    parameter int STRETCH_CYC = RESET_STRETCH_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic enable_in,
    input wire logic standby_select_in,
    input wire logic tx_data_in,
    input wire logic wake_in,
    input wire logic bus_rx_in,
    input wire logic supply_below_in,
    output logic rx_data_out,
    output logic bus_tx_dominant,
    output logic tx_enable,
    output logic low_slope,
    output logic termination_on,
    output logic regulator_on,
    output logic receiver_on,
    output logic inhibit_out,
    output logic inhibit_oe_n,
    output logic mcu_reset_out_n,
    output lnmwrc_mode_t mode
);
    import lnmwrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    lnmwrc_evt_if evt ();
    logic remote_wake_raw;
    logic wake_prev;
    logic en_prev;
    logic remote_seen;
    logic tx_armed;
    logic inh_drive;
    lnmwrc_mode_t next_mode;
    logic next_remote_seen;
    logic next_tx_armed;
    logic next_inh_drive;
    logic inputs_live;
    logic local_wake;
    logic reset_low;

    lnmwrc_wake_det #(.FILTER_CYC(WAKE_CYC)) u_wake (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .enable(mode == LNMWRC_STANDBY || mode == LNMWRC_SLEEP), // see R9
        .bus_rx(bus_rx_in),
        .wake_pulse(remote_wake_raw)
    );
    assign evt.remote_wake = remote_wake_raw;

    lnmwrc_supply_mon #(
        .FILTER_CYC(FILTER_CYC),
        .STRETCH_CYC(STRETCH_CYC)
    ) u_mon (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .monitor_on(mode != LNMWRC_SLEEP), // see R11
        .supply_below(supply_below_in),
        .supply_low(evt.supply_low),
        .reset_hold(evt.reset_hold)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset low in sleep or during supply hold; inputs are then masked
    assign reset_low = evt.reset_hold || mode == LNMWRC_SLEEP; // see R14
    assign inputs_live = !reset_low; // see R15
    // the wake pin is a wake source, not a mode input, so sleep still sees it
    assign local_wake = mode == LNMWRC_SLEEP && (wake_in != wake_prev); // see R7

    always_comb begin
        next_mode = mode;
        next_remote_seen = remote_seen;
        next_tx_armed = tx_armed;
        next_inh_drive = inh_drive;
        if (evt.supply_low) begin
            next_mode = LNMWRC_STANDBY; // see R12
        end else begin
            case (mode)
                LNMWRC_STANDBY: begin
                    if (inputs_live && enable_in && !en_prev) begin
                        next_inh_drive = standby_select_in; // see R18
                        next_remote_seen = 1'b0;
                        if (tx_data_in) begin
                            next_mode = LNMWRC_NORMAL; // see R16
                            next_tx_armed = 1'b1;
                        end else begin
                            next_mode = LNMWRC_LOW_SLOPE; // see R17
                            next_tx_armed = 1'b0;
                        end
                    end
                end
                LNMWRC_NORMAL, LNMWRC_LOW_SLOPE: begin
                    if (inputs_live && !enable_in) begin
                        if (standby_select_in) begin
                            next_mode = LNMWRC_STANDBY; // see R2
                        end else begin
                            next_mode = LNMWRC_SLEEP; // see R5
                        end
                    end
                    if (inputs_live && tx_data_in) begin
                        next_tx_armed = 1'b1; // see R17
                    end
                end
                LNMWRC_SLEEP: begin
                    if (local_wake || evt.remote_wake) begin
                        next_mode = LNMWRC_STANDBY; // see R3
                    end
                end
                default: begin
                    next_mode = LNMWRC_STANDBY; // see R20
                end
            endcase
        end
        if (next_mode == LNMWRC_STANDBY || next_mode == LNMWRC_SLEEP) begin
            next_tx_armed = 1'b0;
        end
        // inhibit floats whenever there is no communication
        if (next_mode == LNMWRC_STANDBY || next_mode == LNMWRC_SLEEP) begin
            next_inh_drive = 1'b0; // see R18
        end
        if (evt.remote_wake) begin
            next_remote_seen = 1'b1; // see R10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode <= LNMWRC_STANDBY; // see R1
            remote_seen <= 1'b0;
            tx_armed <= 1'b0;
            inh_drive <= 1'b0;
            wake_prev <= 1'b0;
            en_prev <= 1'b1;
        end else begin
            mode <= next_mode;
            remote_seen <= next_remote_seen;
            tx_armed <= next_tx_armed;
            inh_drive <= next_inh_drive;
            wake_prev <= wake_in;
            // masked inputs look high so release with enable high is no edge
            en_prev <= inputs_live ? enable_in : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_data_out <= 1'b1;
            bus_tx_dominant <= 1'b0;
            tx_enable <= 1'b0;
            low_slope <= 1'b0;
            termination_on <= 1'b0;
            regulator_on <= 1'b1;
            receiver_on <= 1'b1;
            inhibit_out <= 1'b0;
            inhibit_oe_n <= 1'b1;
            mcu_reset_out_n <= 1'b0;
        end else begin
            if (mode == LNMWRC_NORMAL || mode == LNMWRC_LOW_SLOPE) begin
                rx_data_out <= bus_rx_in; // see R19
            end else if (mode == LNMWRC_STANDBY) begin
                rx_data_out <= !remote_seen; // see R10
            end else begin
                rx_data_out <= 1'b1;
            end
            tx_enable <= tx_armed; // see R4
            bus_tx_dominant <= tx_armed && !tx_data_in;
            low_slope <= mode == LNMWRC_LOW_SLOPE;
            termination_on <= tx_armed || mode == LNMWRC_NORMAL
                || mode == LNMWRC_LOW_SLOPE; // see R4
            regulator_on <= mode != LNMWRC_SLEEP; // see R6
            receiver_on <= 1'b1;
            inhibit_out <= inh_drive;
            inhibit_oe_n <= !inh_drive; // see R18
            mcu_reset_out_n <= !reset_low && next_mode != LNMWRC_SLEEP;
        end
    end
endmodule : lnmwrc_top
`default_nettype wire

// >>> core/lnmwrc_pkg.sv
// lnmwrc_pkg: shared constants and types of the lin node mode/wake/reset control
`default_nettype none
package lnmwrc_pkg;
    localparam int CLK_MHZ = 125;
    // supply-low filter time, ns
    localparam int SUPPLY_LOW_FILTER_NS = 5000;
    localparam int SUPPLY_LOW_FILTER_CYC = (SUPPLY_LOW_FILTER_NS * CLK_MHZ) / 1000;
    // reset stretch after supply recovery, us
    localparam int RESET_STRETCH_US = 6000;
    localparam int RESET_STRETCH_CYC = RESET_STRETCH_US * CLK_MHZ;
    // remote wake dominant filter time, us (least figure)
    localparam int WAKE_FILTER_US = 8;
    localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * CLK_MHZ;
    localparam int CNT_W = 20;

    typedef enum logic [1:0] {
        LNMWRC_STANDBY = 2'b00,
        LNMWRC_NORMAL = 2'b01,
        LNMWRC_LOW_SLOPE = 2'b10,
        LNMWRC_SLEEP = 2'b11
    } lnmwrc_mode_t;
endpackage : lnmwrc_pkg
`default_nettype wire

// >>> core/lnmwrc_evt_if.sv
// lnmwrc_evt_if: wake and supply events passed from the monitors to the mode logic
`default_nettype none
interface lnmwrc_evt_if;
    logic remote_wake;
    logic supply_low;
    logic reset_hold;
    modport mon (output remote_wake, output supply_low, output reset_hold);
    modport ctl (input remote_wake, input supply_low, input reset_hold);
endinterface : lnmwrc_evt_if
`default_nettype wire

// >>> core/lnmwrc_wake_det.sv
// lnmwrc_wake_det: remote bus wake detector
`default_nettype none
module lnmwrc_wake_det
    import lnmwrc_pkg::*;
#(
    parameter int FILTER_CYC = WAKE_FILTER_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic bus_rx,
    output logic wake_pulse
);
    // bus_rx low means dominant
    logic armed;
    logic long_enough;
    logic prev_rx;
    logic [CNT_W-1:0] cnt;
    logic next_armed;
    logic next_long_enough;
    logic [CNT_W-1:0] next_cnt;
    logic next_wake_pulse;

    always_comb begin
        next_armed = armed;
        next_long_enough = long_enough;
        next_cnt = cnt;
        next_wake_pulse = 1'b0;
        if (!enable) begin
            next_armed = 1'b0;
            next_long_enough = 1'b0;
            next_cnt = '0;
        end else if (prev_rx && !bus_rx) begin
            // recessive to dominant edge starts the filter
            next_armed = 1'b1;
            next_long_enough = 1'b0;
            next_cnt = '0;
        end else if (armed && !bus_rx) begin
            if (cnt >= CNT_W'(FILTER_CYC)) begin
                next_long_enough = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end else if (armed && bus_rx) begin
            next_armed = 1'b0;
            next_wake_pulse = long_enough; // see R8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            armed <= 1'b0;
            long_enough <= 1'b0;
            cnt <= '0;
            prev_rx <= 1'b1;
            wake_pulse <= 1'b0;
        end else begin
            armed <= next_armed;
            long_enough <= next_long_enough;
            cnt <= next_cnt;
            prev_rx <= bus_rx;
            wake_pulse <= next_wake_pulse;
        end
    end
endmodule : lnmwrc_wake_det
`default_nettype wire

// >>> core/lnmwrc_supply_mon.sv
// lnmwrc_supply_mon: supply-low filter and reset stretch
`default_nettype none
module lnmwrc_supply_mon
    import lnmwrc_pkg::*;
#(
    parameter int FILTER_CYC = SUPPLY_LOW_FILTER_CYC,
    parameter int STRETCH_CYC = RESET_STRETCH_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic monitor_on,
    input wire logic supply_below,
    output logic supply_low,
    output logic reset_hold
);
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] next_low_cnt;
    logic [CNT_W-1:0] next_hold_cnt;
    logic next_supply_low;
    logic next_reset_hold;

    always_comb begin
        next_low_cnt = '0;
        next_supply_low = 1'b0;
        next_hold_cnt = hold_cnt;
        next_reset_hold = reset_hold;
        if (monitor_on && supply_below) begin
            // debounce: only a lasting dip counts
            if (low_cnt >= CNT_W'(FILTER_CYC)) begin
                next_low_cnt = low_cnt;
                next_supply_low = 1'b1; // see R11
            end else begin
                next_low_cnt = low_cnt + 1'b1;
            end
        end
        // sleep keeps the hold set, so the wake-up gets a full stretch
        if (next_supply_low || !monitor_on) begin
            next_reset_hold = 1'b1; // see R12
            next_hold_cnt = '0;
        end else if (reset_hold && !supply_below) begin
            if (hold_cnt >= CNT_W'(STRETCH_CYC - 1)) begin
                next_reset_hold = 1'b0; // see R13
            end else begin
                next_hold_cnt = hold_cnt + 1'b1;
            end
        end else if (reset_hold) begin
            next_hold_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            low_cnt <= '0;
            hold_cnt <= '0;
            supply_low <= 1'b0;
            // power-up behaves like a recovery from supply low
            reset_hold <= 1'b1;
        end else begin
            low_cnt <= next_low_cnt;
            hold_cnt <= next_hold_cnt;
            supply_low <= next_supply_low;
            reset_hold <= next_reset_hold;
        end
    end
endmodule : lnmwrc_supply_mon
`default_nettype wire

// >>> dv/lnmwrc_line_model.sv
// lnmwrc_line_model: lin bus wire and regulator supply seen by the node
`default_nettype none
module lnmwrc_line_model (
    input wire logic clk_sys,
    input wire logic remote_dom,
    input wire logic dip,
    input wire logic bus_tx_dominant,
    input wire logic tx_enable,
    input wire logic regulator_on,
    output logic bus_rx_in,
    output logic supply_below_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] reg_lag = 2'h3;
    // wired-and bus: recessive through the pull-up unless pulled down
    assign bus_rx_in = ~((bus_tx_dominant & tx_enable) | remote_dom);
    // the supply sags three cycles after the regulator is switched off
    always_ff @(posedge clk_sys) begin
        reg_lag <= {reg_lag[0], regulator_on};
        supply_below_in <= dip | ~reg_lag[1];
    end
endmodule : lnmwrc_line_model
`default_nettype wire

// >>> dv/lnmwrc_properties.sv
// lnmwrc_properties: assertions on the ports of lnmwrc_top
`default_nettype none
module lnmwrc_properties
    import lnmwrc_pkg::*;
#(
    parameter int STRETCH_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tx_data_in,
    input wire logic bus_rx_in,
    input wire logic supply_below_in,
    input wire logic rx_data_out,
    input wire logic tx_enable,
    input wire logic termination_on,
    input wire logic regulator_on,
    input wire logic inhibit_oe_n,
    input wire logic mcu_reset_out_n,
    input wire lnmwrc_mode_t mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // modes 01 and 10 are the two communicating modes
    logic run;
    logic slp;
    int ok_cnt;
    int next_ok_cnt;
    assign run = mode[1] ^ mode[0];
    assign slp = &mode;
    always_comb begin
        next_ok_cnt = (sys_rst || supply_below_in) ? 0 : ok_cnt + 1;
    end
    always_ff @(posedge clk_sys) begin
        ok_cnt <= next_ok_cnt;
    end
    ////////////////////////////////////////////////////////////////////////
    chk_sleep_rst_low: assert property (slp[*2] |-> !mcu_reset_out_n)
        else $error("reset high in sleep");
    chk_standby_quiet: assert property ((mode == LNMWRC_STANDBY)[*2]
        |-> !tx_enable && !termination_on && regulator_on)
        else $error("stand-by outputs wrong");
    chk_sleep_off: assert property (slp[*2]
        |-> !regulator_on && !termination_on)
        else $error("sleep outputs wrong");
    chk_sleep_exit: assert property ($past(slp) && !slp
        |-> mode == LNMWRC_STANDBY)
        else $error("sleep left to wrong mode");
    chk_reset_blocks: assert property ((!mcu_reset_out_n)[*3] |-> !run)
        else $error("normal mode under reset");
    chk_rx_follow: assert property (run[*3]
        |-> rx_data_out == $past(bus_rx_in))
        else $error("rx does not follow bus");
    chk_slope_wait: assert property (mode == LNMWRC_LOW_SLOPE
        && !tx_enable && !tx_data_in && !$past(tx_data_in) |=> !tx_enable)
        else $error("transmitter on before tx high");
    chk_idle_float: assert property ((!run)[*2] |-> inhibit_oe_n)
        else $error("inhibit driven while idle");
    chk_low_supply: assert property (supply_below_in[*8]
        |-> !mcu_reset_out_n && !run)
        else $error("supply low not acted on");
    chk_stretch: assert property ($rose(mcu_reset_out_n)
        |-> ok_cnt >= STRETCH_CYC - 1)
        else $error("reset released too early");
    chk_wake_flag: assert property (mode == LNMWRC_STANDBY
        && !rx_data_out |=> !rx_data_out || run)
        else $error("wake flag lost in stand-by");
    cov_normal: cover property ($past(mode) == LNMWRC_STANDBY && run);
    cov_sleep: cover property ($past(run) && slp);
    cov_remote: cover property ($past(slp) && !slp ##2 !rx_data_out);
endmodule : lnmwrc_properties
bind lnmwrc_top lnmwrc_properties #(.STRETCH_CYC(STRETCH_CYC)) u_props (
    .clk_sys, .sys_rst, .tx_data_in, .bus_rx_in, .supply_below_in,
    .rx_data_out, .tx_enable, .termination_on, .regulator_on,
    .inhibit_oe_n, .mcu_reset_out_n, .mode);
`default_nettype wire

// >>> dv/lnmwrc_top_tb.sv
// lnmwrc_top_tb: self-checking bench of lnmwrc_top
`default_nettype none
module lnmwrc_top_tb
    import lnmwrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STR = 20;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic enable_in = 1'h1;
    logic standby_select_in = 1'h1;
    logic tx_data_in = 1'h1;
    logic wake_in = 1'h0;
    logic remote_dom = 1'h0;
    logic dip = 1'h0;
    logic bus_rx_in, supply_below_in, rx_data_out, bus_tx_dominant;
    logic tx_enable, low_slope, termination_on, regulator_on, receiver_on;
    logic inhibit_out, inhibit_oe_n, mcu_reset_out_n;
    lnmwrc_mode_t mode;
    lnmwrc_mode_t exp_mode = LNMWRC_STANDBY;
    int failures = 0;
    int checked = 0;
    lnmwrc_top #(.WAKE_CYC(8), .FILTER_CYC(4), .STRETCH_CYC(STR)) DUT (
        .clk_sys, .sys_rst, .enable_in, .standby_select_in, .tx_data_in,
        .wake_in, .bus_rx_in, .supply_below_in, .rx_data_out,
        .bus_tx_dominant, .tx_enable, .low_slope, .termination_on,
        .regulator_on, .receiver_on, .inhibit_out, .inhibit_oe_n,
        .mcu_reset_out_n, .mode);
    lnmwrc_line_model u_line (.clk_sys, .remote_dom, .dip, .bus_tx_dominant,
        .tx_enable, .regulator_on, .bus_rx_in, .supply_below_in);
    initial forever #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task check(string name, logic [1:0] seen, logic [1:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %0d seen %0d", name, exp, seen);
        end
    endtask : check
    task tick(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task drive(logic e, logic s, logic t);
        @(posedge clk_sys);
        enable_in <= e;
        standby_select_in <= s;
        tx_data_in <= t;
    endtask : drive
    // mode model: only an enable rise leaves stand-by
    task go(logic e, logic s, logic t);
        if (exp_mode == LNMWRC_STANDBY && e && !enable_in)
            exp_mode = t ? LNMWRC_NORMAL : LNMWRC_LOW_SLOPE;
        else if (exp_mode inside {LNMWRC_NORMAL, LNMWRC_LOW_SLOPE} && !e)
            exp_mode = s ? LNMWRC_STANDBY : LNMWRC_SLEEP;
        drive(e, s, t);
        tick(3);
        check("mode", mode, exp_mode);
    endtask : go
    // b selects a supply sag, otherwise a remote dominant level
    task hold(logic b, int n);
        @(posedge clk_sys);
        if (b)
            dip <= 1'h1;
        else
            remote_dom <= 1'h1;
        repeat (n) @(posedge clk_sys);
        dip <= 1'h0;
        remote_dom <= 1'h0;
        tick(5);
    endtask : hold
    task wait_rst;
        for (int i = 0; i < 100 && mcu_reset_out_n !== 1'h1; i++)
            tick(1);
        check("reset_n", mcu_reset_out_n, 1'h1);
    endtask : wait_rst
    task close_out;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    // whole run takes about 200 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        close_out;
    end
    initial begin
        void'($urandom(94));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'h0;
        tick(2);
        check("mode", mode, exp_mode);
        check("reset_n", mcu_reset_out_n, 1'h0);
        repeat (STR - 6)
            drive(1'($urandom), 1'($urandom), 1'($urandom));
        tick(1);
        check("mode", mode, exp_mode);
        drive(1'h0, 1'h1, 1'h1);
        wait_rst;
        check("reg", regulator_on, 1'h1);
        check("rcv", receiver_on, 1'h1);
        @(posedge clk_sys);
        wake_in <= 1'h1;
        tick(3);
        check("mode", mode, exp_mode);
        go(1'h1, 1'h1, 1'h1);
        check("tx_en", tx_enable, 1'h1);
        check("inh_oe_n", inhibit_oe_n, 1'h0);
        check("inh", inhibit_out, 1'h1);
        @(posedge clk_sys);
        remote_dom <= 1'h1;
        tick(3);
        check("rx", rx_data_out, 1'h0);
        @(posedge clk_sys);
        remote_dom <= 1'h0;
        go(1'h0, 1'h1, 1'h1);
        check("tx_en", tx_enable, 1'h0);
        go(1'h1, 1'h0, 1'h0);
        check("tx_en", tx_enable, 1'h0);
        check("inh_oe_n", inhibit_oe_n, 1'h1);
        go(1'h1, 1'h0, 1'h1);
        check("tx_en", tx_enable, 1'h1);
        go(1'h0, 1'h0, 1'h1);
        check("reset_n", mcu_reset_out_n, 1'h0);
        check("reg", regulator_on, 1'h0);
        repeat (8)
            drive(1'($urandom), 1'($urandom), 1'($urandom));
        hold(1'h0, 4);
        check("mode", mode, exp_mode);
        @(posedge clk_sys);
        wake_in <= 1'h0;
        tick(3);
        exp_mode = LNMWRC_STANDBY;
        check("mode", mode, exp_mode);
        check("rx", rx_data_out, 1'h1);
        drive(1'h0, 1'h1, 1'h1);
        wait_rst;
        go(1'h1, 1'h1, 1'h1);
        go(1'h0, 1'h0, 1'h1);
        hold(1'h0, 12);
        exp_mode = LNMWRC_STANDBY;
        check("mode", mode, exp_mode);
        wait_rst;
        check("rx", rx_data_out, 1'h0);
        go(1'h1, 1'h1, 1'h1);
        check("rx", rx_data_out, 1'h1);
        hold(1'h1, 2);
        check("reset_n", mcu_reset_out_n, 1'h1);
        hold(1'h1, 10);
        exp_mode = LNMWRC_STANDBY;
        check("mode", mode, exp_mode);
        check("reset_n", mcu_reset_out_n, 1'h0);
        wait_rst;
        close_out;
    end
endmodule : lnmwrc_top_tb
`default_nettype wire
